// File: pde_pkg.sv
// shared constants for the presence-detect store serial slave
package pde_pkg;
	// ***********************
	// select byte layout
	// ***********************
	localparam int SEL_TYPE_MSB = 7;
	localparam int SEL_TYPE_LSB = 4;
	localparam int SEL_CE_MSB = 3;
	localparam int SEL_CE_LSB = 1;
	localparam int SEL_RW_BIT = 0;
	// ***********************
	// bit slots within one byte frame
	// ***********************
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] ACK_END = 4'h9;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	// ***********************
	// storage
	// ***********************
	localparam int MEM_ADDR_W = 8;
	localparam int MEM_DEPTH = 256;
	localparam int PAGE_BITS = 4;
	localparam logic [7:0] MEM_RESET = 8'hff;
	localparam logic [7:0] PROT_RESET = 8'h00;
	// ***********************
	// timing
	// ***********************
	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_TIME_MS = 10;
	localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	// ***********************
	// sequencer states
	// ***********************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SEL,
		ST_ADDR,
		ST_WDATA,
		ST_RDATA,
		ST_WAIT
	} pde_state_t;
endpackage : pde_pkg

// File: pde_line_if.sv
// filtered line levels and edges between the pin synchroniser and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface pde_line_if #(parameter int W = 1);
	logic [W-1:0] level;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport drv (output level, output rise, output fall);
	modport use_side (input level, input rise, input fall);
endinterface : pde_line_if
`default_nettype wire

// File: pde_line_sync.sv
// three-stage pin synchroniser with agreement filter and edge flags
`timescale 1ns/1ps
`default_nettype none
module pde_line_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] IDLE_VAL = '0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// raw pins
	input wire logic [W-1:0] pin,
	// filtered result
	pde_line_if.drv line
);
	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;
	logic [W-1:0] level_r;
	logic [W-1:0] prev_r;

	// ***********************
	// sampling chain
	// ***********************
	// only ff2 reads ff1; the filter looks at stages two and three
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ff1_r <= IDLE_VAL;
			ff2_r <= IDLE_VAL;
			ff3_r <= IDLE_VAL;
			level_r <= IDLE_VAL;
			prev_r <= IDLE_VAL;
		end else begin
			ff1_r <= pin;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
			// a change counts only once two stages agree
			level_r <= (ff2_r & ~(ff2_r ^ ff3_r)) | (level_r & (ff2_r ^ ff3_r));
			prev_r <= level_r;
		end
	end

	// edge flags last one cycle
	assign line.level = level_r;
	assign line.rise = level_r & ~prev_r;
	assign line.fall = ~level_r & prev_r;
endmodule : pde_line_sync
`default_nettype wire

// File: pde_slave.sv
// two-wire slave sequencer and storage of the presence-detect store
// What this block does
// RL1 - data-line drive changes only while the clock line is low.
// RL2 - a data fall with the clock high is a start; nothing is answered before one.
// RL3 - a data rise with the clock high is a stop; it ends the transfer and gives standby once no program cycle runs.
// RL4 - after each byte the sender releases data and the receiver pulls it low in clock nine.
// RL5 - a start followed by a matching select byte is acknowledged unless a program cycle is running.
// RL6 - once selected for write, every further received byte is acknowledged.
// RL7 - a read sends eight bits, releases data, samples the master ack and on ack sends on.
// RL8 - on a missing master ack the device stops sending, stays released and waits for stop.
// RL9 - the select byte comes msb first: type in b7-b4, chip enables in b3-b1, read flag in b0.
// RL10 - two type values select memory or protection byte, and chip enables must match the pins.
// RL11 - a memory select with read flag one returns the byte at the internal pointer, a protection select the protection byte.
// RL12 - random read: select with flag zero, word address, repeated start, select with flag one.
// RL13 - sequential reads continue while the master acks, whatever the write-control level.
// RL14 - writes take effect only while write control is low, a page holding sixteen bytes.
// RL15 - after the stop ending a write that took data with write control low the program cycle runs and the address is not acked.
// RL16 - the pointer steps by one after each byte read or written, a write wrapping inside its sixteen-byte page.
`timescale 1ns/1ps
`default_nettype none
module pde_slave #(
	parameter int WRITE_CYCLES_P = pde_pkg::WRITE_CYCLES,
	parameter logic [3:0] MEM_TYPE_ID = 4'h5, // arbitrary value
	parameter logic [3:0] PROT_TYPE_ID = 4'h3 // arbitrary value
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// serial link pins
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// straps and write guard
	input wire logic chip_enable_bit0,
	input wire logic chip_enable_bit1,
	input wire logic chip_enable_bit2,
	input wire logic write_control_pin,
	// status
	output logic standby,
	output logic write_busy
);
	import pde_pkg::*;

	localparam int BW = $clog2(WRITE_CYCLES_P + 1);

	pde_line_if #(.W(1)) scl_l ();
	pde_line_if #(.W(1)) sda_l ();
	pde_line_if #(.W(4)) cfg_l ();

	pde_state_t state_r;
	logic [3:0] cnt_r;
	logic sda_oe_r;
	logic [7:0] shreg_r;
	logic [7:0] txsh_r;
	logic [MEM_ADDR_W-1:0] ptr_r;
	logic rw_r;
	logic area_r;
	logic mack_r;
	logic wrote_r;
	logic busy_r;
	logic [BW-1:0] bcnt_r;
	logic [7:0] mem_r [0:MEM_DEPTH-1];
	logic [7:0] prot_r;
	logic start_ev;
	logic stop_ev;
	logic active;
	logic sel_match;
	logic wr_en;
	logic [7:0] rdata;
	logic [2:0] ce_lvl;
	logic wc_lvl;

	// ***********************
	// pin conditioning
	// ***********************
	pde_line_sync #(.W(1), .IDLE_VAL(1'b1)) u_scl (
		.ref_clk(ref_clk),
		.reset(reset),
		.pin(scl_pin),
		.line(scl_l)
	);
	pde_line_sync #(.W(1), .IDLE_VAL(1'b1)) u_sda (
		.ref_clk(ref_clk),
		.reset(reset),
		.pin(sda_in),
		.line(sda_l)
	);
	pde_line_sync #(.W(4), .IDLE_VAL(4'h0)) u_cfg (
		.ref_clk(ref_clk),
		.reset(reset),
		.pin({write_control_pin, chip_enable_bit2, chip_enable_bit1, chip_enable_bit0}),
		.line(cfg_l)
	);

	// ***********************
	// bus conditions and decode
	// ***********************
	assign ce_lvl = cfg_l.level[2:0];
	assign wc_lvl = cfg_l.level[3];
	assign start_ev = sda_l.fall[0] & scl_l.level[0]; // RL2
	assign stop_ev = sda_l.rise[0] & scl_l.level[0]; // RL3
	assign active = (state_r != ST_IDLE) && (state_r != ST_WAIT);
	// busy device stays deaf to its own address
	assign sel_match = !busy_r && // RL15
		(shreg_r[SEL_CE_MSB:SEL_CE_LSB] == ce_lvl) && // RL10
		((shreg_r[SEL_TYPE_MSB:SEL_TYPE_LSB] == MEM_TYPE_ID) ||
		(shreg_r[SEL_TYPE_MSB:SEL_TYPE_LSB] == PROT_TYPE_ID)); // RL9
	assign wr_en = active && !start_ev && !stop_ev && scl_l.fall[0] &&
		(cnt_r == ACK_SLOT) && (state_r == ST_WDATA) && !wc_lvl; // RL14
	assign rdata = area_r ? prot_r : mem_r[ptr_r];
	assign sda_out = 1'b0; // open drain: only ever pulls low
	assign sda_oe = sda_oe_r;
	assign write_busy = busy_r;
	assign standby = (state_r == ST_IDLE) && !busy_r; // RL3

	// ***********************
	// byte sequencer
	// ***********************
	// inputs sampled on clock rise, drive changed on clock fall
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			cnt_r <= CNT_ZERO;
			sda_oe_r <= 1'b0;
			shreg_r <= 8'h00;
			txsh_r <= 8'h00;
			ptr_r <= '0;
			rw_r <= 1'b0;
			area_r <= 1'b0;
			mack_r <= 1'b0;
			wrote_r <= 1'b0;
		end else if (stop_ev) begin
			state_r <= ST_IDLE; // RL3
			cnt_r <= CNT_ZERO;
			sda_oe_r <= 1'b0;
			wrote_r <= 1'b0;
		end else if (start_ev) begin
			state_r <= ST_SEL; // RL2
			cnt_r <= CNT_ZERO;
			sda_oe_r <= 1'b0;
		end else if (active && scl_l.rise[0]) begin
			if (cnt_r < ACK_SLOT) begin
				shreg_r <= {shreg_r[6:0], sda_l.level[0]}; // RL9
			end
			if (cnt_r == ACK_SLOT) begin
				mack_r <= ~sda_l.level[0]; // RL7
			end
			cnt_r <= cnt_r + CNT_ONE;
		end else if (active && scl_l.fall[0]) begin
			if (cnt_r == ACK_SLOT) begin
				unique case (state_r)
					ST_SEL: begin
						if (sel_match) begin
							sda_oe_r <= 1'b1; // RL5
							rw_r <= shreg_r[SEL_RW_BIT];
							area_r <= (shreg_r[SEL_TYPE_MSB:SEL_TYPE_LSB] == PROT_TYPE_ID); // RL10
						end else begin
							state_r <= ST_IDLE;
						end
					end
					ST_ADDR: begin
						sda_oe_r <= 1'b1; // RL6
						ptr_r <= shreg_r; // RL12
					end
					ST_WDATA: begin
						sda_oe_r <= 1'b1; // RL6
						if (!wc_lvl) begin
							wrote_r <= 1'b1;
						end
						// page roll-over keeps the upper address bits
						ptr_r <= {ptr_r[MEM_ADDR_W-1:PAGE_BITS],
							ptr_r[PAGE_BITS-1:0] + {{(PAGE_BITS-1){1'b0}}, 1'b1}}; // RL16
					end
					ST_RDATA: begin
						sda_oe_r <= 1'b0; // RL4
						ptr_r <= ptr_r + {{(MEM_ADDR_W-1){1'b0}}, 1'b1}; // RL16
					end
					ST_IDLE, ST_WAIT: begin
					end
				endcase
			end else if (cnt_r == ACK_END) begin
				cnt_r <= CNT_ZERO;
				unique case (state_r)
					ST_SEL: begin
						if (rw_r) begin
							state_r <= ST_RDATA; // RL11
							txsh_r <= rdata;
							sda_oe_r <= ~rdata[7];
						end else begin
							state_r <= ST_ADDR; // RL12
							sda_oe_r <= 1'b0;
						end
					end
					ST_ADDR, ST_WDATA: begin
						state_r <= ST_WDATA;
						sda_oe_r <= 1'b0; // RL4
					end
					ST_RDATA: begin
						if (mack_r) begin
							txsh_r <= rdata; // RL13
							sda_oe_r <= ~rdata[7];
						end else begin
							state_r <= ST_WAIT; // RL8
							sda_oe_r <= 1'b0;
						end
					end
					ST_IDLE, ST_WAIT: begin
					end
				endcase
			end else if (state_r == ST_RDATA && cnt_r != CNT_ZERO) begin
				txsh_r <= {txsh_r[6:0], 1'b0}; // RL7
				sda_oe_r <= ~txsh_r[6]; // RL1
			end
		end
	end

	// ***********************
	// storage
	// ***********************
	// flop array; reads ignore write control entirely
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem_r[i] <= MEM_RESET;
			end
			prot_r <= PROT_RESET;
		end else if (wr_en) begin
			if (area_r) begin
				prot_r <= shreg_r; // RL14
			end else begin
				mem_r[ptr_r] <= shreg_r; // RL14
			end
		end
	end

	// ***********************
	// program cycle timer
	// ***********************
	// starts only on the stop that closes a write with data taken
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busy_r <= 1'b0;
			bcnt_r <= '0;
		end else if (stop_ev && wrote_r) begin
			busy_r <= 1'b1; // RL15
			bcnt_r <= BW'(WRITE_CYCLES_P - 1);
		end else if (busy_r) begin
			if (bcnt_r == '0) begin
				busy_r <= 1'b0;
			end else begin
				bcnt_r <= bcnt_r - {{(BW-1){1'b0}}, 1'b1};
			end
		end
	end

	// ***********************
	// checks
	// ***********************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	chk_start_select: assert property (start_ev && !stop_ev |=> // RL2
		state_r == ST_SEL && cnt_r == CNT_ZERO) else $error("start not taken");
	chk_stop_idle: assert property (stop_ev |=> state_r == ST_IDLE && !sda_oe_r) // RL3
		else $error("stop not honoured");
	chk_drive_clock_low: assert property ($changed(sda_oe_r) && !$past(start_ev) && // RL1
		!$past(stop_ev) |-> !scl_l.level[0]) else $error("data drive changed with clock high");
	chk_select_ack: assert property (active && scl_l.fall[0] && !start_ev && !stop_ev && // RL5
		state_r == ST_SEL && cnt_r == ACK_SLOT && sel_match |=> sda_oe_r)
		else $error("matching select not acked");
	chk_busy_deaf: assert property (busy_r && scl_l.fall[0] && !start_ev && !stop_ev && // RL15
		state_r == ST_SEL && cnt_r == ACK_SLOT |=> state_r == ST_IDLE && !sda_oe_r)
		else $error("address acked while programming");
	chk_write_ack: assert property (active && scl_l.fall[0] && !start_ev && !stop_ev && // RL6
		state_r == ST_WDATA && cnt_r == ACK_SLOT |=> sda_oe_r) else $error("write byte not acked");
	chk_read_release: assert property (active && scl_l.fall[0] && !start_ev && !stop_ev && // RL16
		state_r == ST_RDATA && cnt_r == ACK_SLOT |=> !sda_oe_r && ptr_r == $past(ptr_r) + 8'h01)
		else $error("read ack slot wrong");
	chk_nack_wait: assert property (active && scl_l.fall[0] && !start_ev && !stop_ev && // RL8
		state_r == ST_RDATA && cnt_r == ACK_END && !mack_r |=> state_r == ST_WAIT && !sda_oe_r)
		else $error("no stop wait after nack");
	// guarded cycles must leave the protection byte and, for a memory select, the addressed word untouched
	chk_write_guard: assert property (wc_lvl |=> $stable(prot_r) && // RL14
		($past(area_r) || mem_r[$past(ptr_r)] == $past(rdata)))
		else $error("write while guarded");
	chk_idle_quiet: assert property (state_r == ST_IDLE || state_r == ST_WAIT |-> !sda_oe_r) // RL2
		else $error("driving while idle");
	chk_busy_length: assert property ($rose(busy_r) |-> busy_r [*8]) // RL15
		else $error("program cycle too short");
endmodule : pde_slave
`default_nettype wire

// File: pde_top_note_end.sv
// empty compilation unit: the block's logic lives in the other files
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: pde_host_model.sv
// host-side bus master model for the two-wire link, 125 ns serial clock
`timescale 1ns/1ps
`default_nettype none
module pde_host_model (
	// bus lines
	output logic scl,
	output logic sda_pull,
	// wire level seen by every party
	input wire logic sda
);
	// ***********************
	// bit-level driving
	// ***********************
	// idle: clock stands high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// low 75 ns, high 50 ns; late sample leaves room for the slave's sync delay
	task automatic bit_io(input logic tx, output logic rx);
		scl = 1'b0;
		#40 sda_pull = !tx;
		#35 scl = 1'b1;
		#50 rx = sda;
	endtask : bit_io
	// data falls while the clock is high; also serves as repeated start
	task automatic start();
		scl = 1'b0;
		#40 sda_pull = 1'b0;
		#35 scl = 1'b1;
		#40 sda_pull = 1'b1;
		#40;
	endtask : start
	// data rises while the clock is high
	task automatic stop();
		scl = 1'b0;
		#40 sda_pull = 1'b1;
		#35 scl = 1'b1;
		#40 sda_pull = 1'b0;
		#40;
	endtask : stop
	// byte out msb first, then release data and sample the slave's ack
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask : wbyte
	// byte in msb first, then own ack (pull low) or nack (release)
	task automatic rbyte(input logic ack_it, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(!ack_it, r);
	endtask : rbyte
endmodule : pde_host_model
`default_nettype wire

// File: tb_presence_detect_eeprom_slave.sv
// self-checking bench: host model against the serial slave and a behavioural store
`timescale 1ns/1ps
`default_nettype none
module tb_presence_detect_eeprom_slave;
	import pde_pkg::*;
	// ***********************
	// set-up
	// ***********************
	localparam int WC = 400; // long enough to span a whole select byte
	localparam logic [3:0] MEM_ID = 4'h5; // arbitrary value
	localparam logic [3:0] PROT_ID = 4'h3; // arbitrary value
	logic ref_clk, reset, scl, host_pull, sda_out, sda_oe, wctl, standby, write_busy;
	logic [2:0] ce;
	logic [7:0] mem [MEM_DEPTH];
	logic [7:0] prot, a, d;
	int ptr, miscompares, comparisons;
	wire logic sda;
	// open-drain wire with pull-up
	assign sda = !((sda_oe && !sda_out) || host_pull);
	pde_slave #(.WRITE_CYCLES_P(WC), .MEM_TYPE_ID(MEM_ID), .PROT_TYPE_ID(PROT_ID)) i_dut (
		.ref_clk(ref_clk), .reset(reset), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .chip_enable_bit0(ce[0]), .chip_enable_bit1(ce[1]),
		.chip_enable_bit2(ce[2]), .write_control_pin(wctl), .standby(standby),
		.write_busy(write_busy));
	pde_host_model i_host (.scl(scl), .sda_pull(host_pull), .sda(sda));
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte
	task automatic chk_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic test_done();
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done
	// start plus select byte, ack compared with the expectation
	task automatic sel(input logic [3:0] id, input logic [2:0] c, input logic rw, input logic exp);
		logic ak;
		// the 125 ns bit time alternates clock phase; a quarter offset keeps pin edges
		// clear of both clock edges
		@(negedge ref_clk);
		#2.5;
		i_host.start();
		i_host.wbyte({id, c, rw}, ak);
		chk_bit("select ack", exp, ak);
	endtask : sel
	// bounded wait on the program-cycle flag
	task automatic wait_busy(input logic lvl, input int lim);
		// looked at on the falling edge, where the flag is settled
		for (int i = 0; i < lim && write_busy !== lvl; i++) begin
			@(negedge ref_clk);
		end
		chk_bit("write busy", lvl, write_busy);
	endtask : wait_busy
	// write n bytes from ad; the model wraps inside the 16-byte page
	task automatic wr(input logic [3:0] id, input logic [7:0] ad, input int n);
		logic [7:0] v;
		logic ak;
		sel(id, ce, 1'b0, 1'b1);
		i_host.wbyte(ad, ak);
		chk_bit("address ack", 1'b1, ak);
		for (int i = 0; i < n; i++) begin
			v = 8'($urandom);
			i_host.wbyte(v, ak);
			chk_bit("data ack", 1'b1, ak);
			if (!wctl && id == PROT_ID) prot = v;
			else if (!wctl) mem[{ad[7:4], ad[3:0] + 4'(i)}] = v;
		end
		i_host.stop();
		// blocked writes store nothing, so no program cycle follows
		if (!wctl) begin
			wait_busy(1'b1, 20);
			chk_bit("standby while programming", 1'b0, standby);
			sel(MEM_ID, ce, 1'b1, 1'b0);
			i_host.stop();
			wait_busy(1'b0, WC + 50);
		end
	endtask : wr
	// random read of n bytes, the last one left without ack
	task automatic rd(input logic [3:0] id, input logic [7:0] ad, input int n);
		logic [7:0] v;
		logic ak;
		sel(id, ce, 1'b0, 1'b1);
		i_host.wbyte(ad, ak);
		chk_bit("address ack", 1'b1, ak);
		sel(id, ce, 1'b1, 1'b1);
		for (int i = 0; i < n; i++) begin
			i_host.rbyte(i < n - 1, v);
			chk_byte("read data", id == PROT_ID ? prot : mem[8'(ad + i)], v);
		end
		if (id != PROT_ID) ptr = (ad + n) % MEM_DEPTH;
		i_host.stop();
	endtask : rd
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// device drive changes only in the clock-low phase
	always @(sda_oe) begin
		if (reset === 1'b0) chk_bit("clock low at drive change", 1'b0, scl);
	end
	// watchdog, about three times the expected run
	initial begin
		#300000;
		miscompares++;
		test_done();
	end
	// ***********************
	// scenarios
	// ***********************
	initial begin
		reset = 1'b1;
		wctl = 1'b0;
		ce = 3'h0;
		prot = PROT_RESET;
		ptr = 0;
		miscompares = 0;
		comparisons = 0;
		foreach (mem[i]) mem[i] = MEM_RESET;
		void'($urandom(66));
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		ce = 3'($urandom);
		chk_bit("standby after reset", 1'b1, standby);
		chk_bit("busy after reset", 1'b0, write_busy);
		repeat (10) @(negedge ref_clk);
		for (int k = 0; k < 3; k++) begin
			sel(MEM_ID, ce ^ 3'(1 << k), 1'b0, 1'b0);
			i_host.stop();
		end
		sel(4'hc, ce, 1'b1, 1'b0);
		i_host.stop();
		a = 8'($urandom);
		wr(MEM_ID, a, 16);
		// crosses into the written page and leaves the pointer on a written word
		rd(MEM_ID, {a[7:4], 4'h0} - 8'h01, 16);
		sel(MEM_ID, ce, 1'b1, 1'b1);
		i_host.rbyte(1'b0, d);
		chk_byte("current read", mem[ptr], d);
		i_host.rbyte(1'b0, d);
		chk_byte("silent after nack", 8'hff, d);
		i_host.stop();
		repeat (10) @(negedge ref_clk);
		chk_bit("standby after stop", 1'b1, standby);
		wctl = 1'b1;
		wr(MEM_ID, a, 2);
		rd(MEM_ID, a, 2);
		@(negedge ref_clk);
		wctl = 1'b0;
		wr(PROT_ID, 8'h00, 1);
		rd(PROT_ID, 8'h00, 1);
		rd(MEM_ID, 8'hfe, 4);
		test_done();
	end
endmodule : tb_presence_detect_eeprom_slave
`default_nettype wire
